// ### src/cti_pkg.sv
// constants, field layouts, codes and states of the camera trigger i/o unit
// assumes one 10 MHz clock and a plain strobe register port
// Summary of operation
// - pulse width sets exposure in pulse-width mode
// - source code 4 selects pulse-width; line field picks input
// - each line direction set individually, input or output
// - inputs debounced; pulses shorter than time discarded
// - per-line debounce time, 0 to 20000 microseconds
// - output mode 0 ready, 1 exposure, 2 strobe, 3 user
// - line index 0 to 3 selects line for configuration
// - per-line inversion drives complement of source
// - ready low at exposure start, high after last readout
// - triggers ignored while ready is low, except a pulse that starts the next frame of a pulse-width burst
// - exposure output high exactly while sensor exposes
// - burst count 1 to 1023 frames per trigger
// - high pulse on selected line is the trigger
// - strobe zero follows exposure, else fixed duration
// - user value low three bits drive matching lines
package cti_pkg;

    // ----------------
    // sizes
    // ----------------
    localparam int NUM_LINES  = 4;
    localparam int LINE_IDX_W = 2;
    localparam int ADDR_W     = 8;
    localparam int DATA_W     = 32;
    localparam int DB_W       = 15;
    localparam int BURST_W    = 10;
    localparam int EXP_W      = 24;
    localparam int STRB_W     = 16;
    localparam int RDO_W      = 16;
    localparam int TICK_W     = 4;
    localparam int USER_W     = 3;

    // ----------------
    // timing
    // ----------------
    localparam int CLOCK_HZ      = 10_000_000;
    localparam int HZ_PER_MHZ    = 1_000_000;
    localparam int CYCLES_PER_US = CLOCK_HZ / HZ_PER_MHZ;
    localparam logic [TICK_W-1:0]  TICK_LAST       = TICK_W'(CYCLES_PER_US - 1);
    localparam logic [DB_W-1:0]    DEBOUNCE_MAX_US = 15'h4E20;
    localparam logic [BURST_W-1:0] BURST_MIN       = 10'h001;

    // ----------------
    // register offsets
    // ----------------
    localparam logic [ADDR_W-1:0] OFF_CTRL     = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_LINE_SEL = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_LINE_CFG = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_DEBOUNCE = 8'h0C;
    localparam logic [ADDR_W-1:0] OFF_BURST    = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_EXPOSE   = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_STROBE   = 8'h18;
    localparam logic [ADDR_W-1:0] OFF_USER     = 8'h1C;
    localparam logic [ADDR_W-1:0] OFF_SOFT     = 8'h20;
    localparam logic [ADDR_W-1:0] OFF_STATUS   = 8'h24;

    // ----------------
    // field positions
    // ----------------
    localparam int CTRL_MODE_BIT = 0;
    localparam int CTRL_SRC_LSB  = 1;
    localparam int CTRL_SRC_MSB  = 3;
    localparam int CTRL_LINE_LSB = 4;
    localparam int CTRL_LINE_MSB = 5;
    localparam int CFG_DIR_BIT   = 0;
    localparam int CFG_INV_BIT   = 1;
    localparam int CFG_MODE_LSB  = 2;
    localparam int CFG_MODE_MSB  = 3;
    localparam int SOFT_BIT      = 0;
    localparam int STAT_READY    = 0;
    localparam int STAT_EXPOSE   = 1;
    localparam int STAT_STROBE   = 2;
    localparam int STAT_IN_LSB   = 4;
    localparam int STAT_IN_MSB   = 7;
    localparam int STAT_FR_LSB   = 8;
    localparam int STAT_FR_MSB   = 17;

    // ----------------
    // reset values and codes
    // ----------------
    localparam logic [EXP_W-1:0]   EXPOSE_RESET = 24'h0003E8;
    localparam logic [BURST_W-1:0] BURST_RESET  = 10'h001;
    localparam logic [2:0] SRC_SOFT  = 3'h0;
    localparam logic [2:0] SRC_EXT   = 3'h1;
    localparam logic [2:0] SRC_PULSE = 3'h4;
    localparam logic [1:0] OUT_READY  = 2'h0;
    localparam logic [1:0] OUT_EXPOSE = 2'h1;
    localparam logic [1:0] OUT_STROBE = 2'h2;
    localparam logic [1:0] OUT_USER   = 2'h3;

    typedef enum {ST_IDLE, ST_EXPOSE, ST_READOUT, ST_ARM} cti_state_type;

endpackage

// ### src/cti_debounce.sv
// one input line: two-stage synchroniser and a pulse width filter
// assumes a one-microsecond tick and a static debounce time
`timescale 1ns/100ps
module cti_debounce (
    // clock and reset
    input  wire logic                  clock_i,
    input  wire logic                  reset_i,
    // timing
    input  wire logic                  tick_i,
    input  wire logic [cti_pkg::DB_W-1:0] time_us_i,
    // line
    input  wire logic                  pin_i,
    output logic                       level_o
);
    import cti_pkg::*;

    logic            sync_a;
    logic            sync_b;
    logic [DB_W-1:0] held;
    wire             differs = (sync_b != level_o);
    wire             long_enough = (time_us_i == '0) || (held > time_us_i);

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
        end else begin
            sync_a <= pin_i;
            sync_b <= sync_a;
        end
    end

    // one tick past the debounce time, so tick phase cannot pass a short pulse
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            held    <= '0;
            level_o <= 1'b0;
        end else if (!differs) begin
            held <= '0;
        end else if (long_enough) begin
            level_o <= sync_b;
            held    <= '0;
        end else if (tick_i) begin
            held <= held + 1'b1;
        end
    end

endmodule

// ### src/cti_out_line.sv
// one output line: source select, inversion and direction, all registered
// assumes indication inputs on the same clock
`timescale 1ns/100ps
module cti_out_line (
    // clock and reset
    input  wire logic       clock_i,
    input  wire logic       reset_i,
    // configuration
    input  wire logic [1:0] mode_i,
    input  wire logic       invert_i,
    input  wire logic       drive_i,
    // sources
    input  wire logic       ready_i,
    input  wire logic       expose_i,
    input  wire logic       strobe_i,
    input  wire logic       user_i,
    // pin
    output logic            line_o,
    output logic            line_oe_n_o
);
    import cti_pkg::*;

    wire chosen = (mode_i == OUT_READY)  ? ready_i  :
                  (mode_i == OUT_EXPOSE) ? expose_i :
                  (mode_i == OUT_STROBE) ? strobe_i : user_i;

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            line_o      <= 1'b0;
            line_oe_n_o <= 1'b1;
        end else begin
            line_o      <= chosen ^ invert_i;
            line_oe_n_o <= ~drive_i;
        end
    end

endmodule

// ### src/cti_top.sv
// trigger input and signal output unit: registers, trigger sequencer, four lines
// assumes asynchronous pins and non-overlapping strobes
//
// Added by the designer: the register offsets and the plain strobed port.
`timescale 1ns/100ps
module cti_top #(
    parameter int READOUT_US = 1000
) (
    // clock and reset
    input  wire logic                          clock_i,
    input  wire logic                          reset_i,
    // register port
    input  wire logic [cti_pkg::ADDR_W-1:0]    reg_addr_i,
    input  wire logic [cti_pkg::DATA_W-1:0]    reg_wdata_i,
    input  wire logic                          reg_write_i,
    input  wire logic                          reg_read_i,
    output logic      [cti_pkg::DATA_W-1:0]    reg_rdata_o,
    // lines
    input  wire logic [cti_pkg::NUM_LINES-1:0] line_in_i,
    output logic      [cti_pkg::NUM_LINES-1:0] line_out_o,
    output logic      [cti_pkg::NUM_LINES-1:0] line_oe_n_o,
    // state
    output logic                               trigger_ready_o,
    output logic                               exposing_o
);
    import cti_pkg::*;

    // ----------------------------------------------------------------
    // configuration registers
    // ----------------------------------------------------------------
    logic                  trig_mode;
    logic [2:0]            trig_src;
    logic [LINE_IDX_W-1:0] trig_line;
    logic [LINE_IDX_W-1:0] line_sel;
    logic [NUM_LINES-1:0]  line_dir;
    logic [NUM_LINES-1:0]  line_inv;
    logic [1:0]            line_mode [NUM_LINES];
    logic [DB_W-1:0]       db_time   [NUM_LINES];
    logic [BURST_W-1:0]    burst;
    logic [EXP_W-1:0]      expose_us;
    logic [STRB_W-1:0]     strobe_us;
    logic [USER_W-1:0]     user_val;

    // ----------------------------------------------------------------
    // sequencer state
    // ----------------------------------------------------------------
    cti_state_type      state;
    cti_state_type      next_state;
    logic [BURST_W-1:0] frames_left;
    logic [BURST_W-1:0] next_frames_left;
    logic [EXP_W-1:0]   exp_cnt;
    logic [EXP_W-1:0]   next_exp_cnt;
    logic [RDO_W-1:0]   rdo_cnt;
    logic [RDO_W-1:0]   next_rdo_cnt;
    logic [STRB_W-1:0]  strb_cnt;
    logic [STRB_W-1:0]  next_strb_cnt;
    logic               strobe;
    logic               next_strobe;
    logic               sel_prev;
    logic [TICK_W-1:0]  tick_cnt;
    logic               tick;
    logic [NUM_LINES-1:0] db_level;

    // ----------------------------------------------------------------
    // one microsecond tick
    // ----------------------------------------------------------------
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            tick_cnt <= '0;
            tick     <= 1'b0;
        end else begin
            tick_cnt <= (tick_cnt == TICK_LAST) ? '0 : tick_cnt + 1'b1;
            tick     <= (tick_cnt == TICK_LAST);
        end
    end

    // ----------------------------------------------------------------
    // register decode
    // ----------------------------------------------------------------
    wire wr_ctrl  = reg_write_i && (reg_addr_i == OFF_CTRL);
    wire wr_sel   = reg_write_i && (reg_addr_i == OFF_LINE_SEL);
    wire wr_cfg   = reg_write_i && (reg_addr_i == OFF_LINE_CFG);
    wire wr_db    = reg_write_i && (reg_addr_i == OFF_DEBOUNCE);
    wire wr_burst = reg_write_i && (reg_addr_i == OFF_BURST);
    wire wr_exp   = reg_write_i && (reg_addr_i == OFF_EXPOSE);
    wire wr_strb  = reg_write_i && (reg_addr_i == OFF_STROBE);
    wire wr_user  = reg_write_i && (reg_addr_i == OFF_USER);
    wire wr_soft  = reg_write_i && (reg_addr_i == OFF_SOFT);

    // debounce time is clamped to its top value
    wire [DB_W-1:0] db_in = (reg_wdata_i[DATA_W-1:DB_W] != '0 ||
                             reg_wdata_i[DB_W-1:0] > DEBOUNCE_MAX_US) ?
                            DEBOUNCE_MAX_US : reg_wdata_i[DB_W-1:0];
    // a burst of zero is taken as one frame
    wire [BURST_W-1:0] burst_in = (reg_wdata_i[BURST_W-1:0] == '0) ?
                                  BURST_MIN : reg_wdata_i[BURST_W-1:0];
    wire [DATA_W-1:0] cfg_word = {{(DATA_W-CFG_MODE_MSB-1){1'b0}}, line_mode[line_sel],
                                  line_inv[line_sel], line_dir[line_sel]};
    wire [DATA_W-1:0] ctrl_word = {{(DATA_W-CTRL_LINE_MSB-1){1'b0}}, trig_line,
                                   trig_src, trig_mode};
    wire [DATA_W-1:0] stat_word = {{(DATA_W-STAT_FR_MSB-1){1'b0}}, frames_left, db_level,
                                   1'b0, strobe, exposing_o, trigger_ready_o};

    wire [DATA_W-1:0] rd_value =
        (reg_addr_i == OFF_CTRL)     ? ctrl_word :
        (reg_addr_i == OFF_LINE_SEL) ? DATA_W'(line_sel) :
        (reg_addr_i == OFF_LINE_CFG) ? cfg_word :
        (reg_addr_i == OFF_DEBOUNCE) ? DATA_W'(db_time[line_sel]) :
        (reg_addr_i == OFF_BURST)    ? DATA_W'(burst) :
        (reg_addr_i == OFF_EXPOSE)   ? DATA_W'(expose_us) :
        (reg_addr_i == OFF_STROBE)   ? DATA_W'(strobe_us) :
        (reg_addr_i == OFF_USER)     ? DATA_W'(user_val) :
        (reg_addr_i == OFF_STATUS)   ? stat_word : '0;

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            reg_rdata_o <= '0;
        end else begin
            reg_rdata_o <= reg_read_i ? rd_value : '0;
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            trig_mode <= 1'b0;
            trig_src  <= SRC_SOFT;
            trig_line <= '0;
            line_sel  <= '0;
            burst     <= BURST_RESET;
            expose_us <= EXPOSE_RESET;
            strobe_us <= '0;
            user_val  <= '0;
        end else begin
            if (wr_ctrl) begin
                trig_mode <= reg_wdata_i[CTRL_MODE_BIT];
                trig_src  <= reg_wdata_i[CTRL_SRC_MSB:CTRL_SRC_LSB];
                trig_line <= reg_wdata_i[CTRL_LINE_MSB:CTRL_LINE_LSB];
            end
            if (wr_sel) begin
                line_sel <= reg_wdata_i[LINE_IDX_W-1:0];
            end
            if (wr_burst) begin
                burst <= burst_in;
            end
            if (wr_exp) begin
                expose_us <= reg_wdata_i[EXP_W-1:0];
            end
            if (wr_strb) begin
                strobe_us <= reg_wdata_i[STRB_W-1:0];
            end
            if (wr_user) begin
                user_val <= reg_wdata_i[USER_W-1:0];
            end
        end
    end

    // per-line settings land in the line picked by the index
    genvar gl;
    generate
        for (gl = 0; gl < NUM_LINES; gl++) begin : g_cfg
            wire hit = (line_sel == LINE_IDX_W'(gl));
            always_ff @(posedge clock_i) begin
                if (reset_i) begin
                    line_dir[gl]  <= 1'b0;
                    line_inv[gl]  <= 1'b0;
                    line_mode[gl] <= OUT_READY;
                    db_time[gl]   <= '0;
                end else begin
                    if (wr_cfg && hit) begin
                        line_dir[gl]  <= reg_wdata_i[CFG_DIR_BIT];
                        line_inv[gl]  <= reg_wdata_i[CFG_INV_BIT];
                        line_mode[gl] <= reg_wdata_i[CFG_MODE_MSB:CFG_MODE_LSB];
                    end
                    if (wr_db && hit) begin
                        db_time[gl] <= db_in;
                    end
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // trigger detection
    // ----------------------------------------------------------------
    wire sel_level = db_level[trig_line] & ~line_dir[trig_line];
    wire sel_rise  = sel_level & ~sel_prev;
    wire sel_fall  = ~sel_level & sel_prev;
    wire pulse_mode = trig_mode && (trig_src == SRC_PULSE);
    wire ext_mode   = trig_mode && (trig_src == SRC_EXT);
    wire soft_mode  = trig_mode && (trig_src == SRC_SOFT);
    wire soft_pulse = wr_soft && reg_wdata_i[SOFT_BIT];
    // trigger is used in idle only; in a pulse-width burst the arm state also takes a rising pulse while not ready
    wire trigger = ((pulse_mode || ext_mode) && sel_rise) ||
                   (soft_mode && soft_pulse);
    wire [EXP_W-1:0] exp_next = exp_cnt + 1'b1;
    wire [RDO_W-1:0] rdo_next = rdo_cnt + 1'b1;
    wire exp_done = pulse_mode ? sel_fall :
                    (tick && (exp_next >= expose_us));
    wire rdo_done = tick && (rdo_next >= RDO_W'(READOUT_US));

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            sel_prev <= 1'b0;
        end else begin
            sel_prev <= sel_level;
        end
    end

    // ----------------------------------------------------------------
    // trigger sequencer
    // ----------------------------------------------------------------
    always_comb begin
        next_state       = state;
        next_frames_left = frames_left;
        next_exp_cnt     = exp_cnt;
        next_rdo_cnt     = rdo_cnt;
        case (state)
            ST_IDLE: begin
                if (trigger) begin
                    next_state       = ST_EXPOSE;
                    next_frames_left = burst;
                    next_exp_cnt     = '0;
                end
            end
            ST_EXPOSE: begin
                if (exp_done) begin
                    next_state   = ST_READOUT;
                    next_rdo_cnt = '0;
                end else if (tick) begin
                    next_exp_cnt = exp_next;
                end
            end
            ST_READOUT: begin
                if (rdo_done) begin
                    next_exp_cnt = '0;
                    if (frames_left <= BURST_MIN) begin
                        next_state       = ST_IDLE;
                        next_frames_left = '0;
                    end else begin
                        next_frames_left = frames_left - 1'b1;
                        next_state       = pulse_mode ? ST_ARM : ST_EXPOSE;
                    end
                end else if (tick) begin
                    next_rdo_cnt = rdo_next;
                end
            end
            ST_ARM: begin
                // later frames of a pulse-width burst each wait for their own pulse
                if (!pulse_mode) begin
                    next_state       = ST_IDLE;
                    next_frames_left = '0;
                end else if (sel_rise) begin
                    next_state = ST_EXPOSE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // strobe follows the exposure when its duration is zero
    wire exp_start = (next_state == ST_EXPOSE) && (state != ST_EXPOSE);
    always_comb begin
        next_strobe   = strobe;
        next_strb_cnt = strb_cnt;
        if (strobe_us == '0) begin
            next_strobe = (next_state == ST_EXPOSE);
        end else if (exp_start) begin
            next_strobe   = 1'b1;
            next_strb_cnt = strobe_us;
        end else if (strobe && tick) begin
            next_strb_cnt = strb_cnt - 1'b1;
            next_strobe   = (strb_cnt > STRB_W'(1));
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            state           <= ST_IDLE;
            frames_left     <= '0;
            exp_cnt         <= '0;
            rdo_cnt         <= '0;
            strb_cnt        <= '0;
            strobe          <= 1'b0;
            trigger_ready_o <= 1'b1;
            exposing_o      <= 1'b0;
        end else begin
            state           <= next_state;
            frames_left     <= next_frames_left;
            exp_cnt         <= next_exp_cnt;
            rdo_cnt         <= next_rdo_cnt;
            strb_cnt        <= next_strb_cnt;
            strobe          <= next_strobe;
            trigger_ready_o <= (next_state == ST_IDLE);
            exposing_o      <= (next_state == ST_EXPOSE);
        end
    end

    // ----------------------------------------------------------------
    // line instances
    // ----------------------------------------------------------------
    generate
        for (gl = 0; gl < NUM_LINES; gl++) begin : g_line
            cti_debounce u_db (
                .clock_i   (clock_i),
                .reset_i   (reset_i),
                .tick_i    (tick),
                .time_us_i (db_time[gl]),
                .pin_i     (line_in_i[gl]),
                .level_o   (db_level[gl])
            );
            // lines past the user value width hold low in user mode unless inverted
            wire user_bit = (gl < USER_W) ? user_val[gl % USER_W] : 1'b0;
            cti_out_line u_out (
                .clock_i     (clock_i),
                .reset_i     (reset_i),
                .mode_i      (line_mode[gl]),
                .invert_i    (line_inv[gl]),
                .drive_i     (line_dir[gl]),
                .ready_i     (trigger_ready_o),
                .expose_i    (exposing_o),
                .strobe_i    (strobe),
                .user_i      (user_bit),
                .line_o      (line_out_o[gl]),
                .line_oe_n_o (line_oe_n_o[gl])
            );
        end
    endgenerate

endmodule

// ### testbench/cti_top_props.sv
// port assertions for the trigger i/o unit
// assumes a bind onto cti_top
`timescale 1ns/100ps
module cti_top_props (
    // clock and reset
    input wire logic                          clock_i,
    input wire logic                          reset_i,
    // register port
    input wire logic [cti_pkg::ADDR_W-1:0]    reg_addr_i,
    input wire logic [cti_pkg::DATA_W-1:0]    reg_wdata_i,
    input wire logic                          reg_write_i,
    input wire logic                          reg_read_i,
    input wire logic [cti_pkg::DATA_W-1:0]    reg_rdata_o,
    // lines and state
    input wire logic [cti_pkg::NUM_LINES-1:0] line_in_i,
    input wire logic [cti_pkg::NUM_LINES-1:0] line_oe_n_o,
    input wire logic                          trigger_ready_o,
    input wire logic                          exposing_o
);
    import cti_pkg::*;
    logic [5:0] ctrl;
    wire        pw  = ctrl[0] && ctrl[3:1] == SRC_PULSE;
    wire        pin = line_in_i[ctrl[5:4]];
    default clocking @(posedge clock_i); endclocking
    default disable iff (reset_i);
    // shadow of the trigger control word
    always_ff @(posedge clock_i) begin
        if (reset_i) ctrl <= 6'h00;
        else if (reg_write_i && reg_addr_i == OFF_CTRL) ctrl <= reg_wdata_i[5:0];
    end
    sequence s_expose_end; exposing_o ##1 !exposing_o; endsequence
    sequence s_pin_high; (pw && pin) [*4]; endsequence
    property p_reset_state; $fell(reset_i) |-> trigger_ready_o && !exposing_o && &line_oe_n_o;
    endproperty
    property p_start; $fell(trigger_ready_o) |-> $rose(exposing_o); endproperty
    property p_busy; exposing_o |-> !trigger_ready_o; endproperty
    property p_readout; s_expose_end |-> !trigger_ready_o [*8]; endproperty
    property p_rdata_idle; !$past(reg_read_i) |-> reg_rdata_o == 32'h0; endproperty
    property p_dir; $changed(line_oe_n_o) |->
        $past(reg_write_i) || $past(reg_write_i, 2) || $past(reg_write_i, 3); endproperty
    property p_pulse_hold; s_pin_high ##0 exposing_o |=> exposing_o; endproperty
    property p_pulse_end; (pw && exposing_o && !pin) ##1 (pw && !pin) [*7] |-> !exposing_o;
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("bad state after reset");
    a_start: assert property (p_start) else $error("ready fell without exposure");
    a_busy: assert property (p_busy) else $error("ready while exposing");
    a_readout: assert property (p_readout) else $error("ready before readout");
    a_rdata_idle: assert property (p_rdata_idle) else $error("stray read data");
    a_dir: assert property (p_dir) else $error("direction changed unasked");
    a_pulse_hold: assert property (p_pulse_hold) else $error("exposure cut short");
    a_pulse_end: assert property (p_pulse_end) else $error("exposure overran pulse");
endmodule
bind cti_top cti_top_props cti_top_props_inst (.clock_i(clock_i), .reset_i(reset_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i),
    .reg_read_i(reg_read_i), .reg_rdata_o(reg_rdata_o), .line_in_i(line_in_i),
    .line_oe_n_o(line_oe_n_o), .trigger_ready_o(trigger_ready_o), .exposing_o(exposing_o));

// ### testbench/cti_src_model.sv
// external trigger source driving the input pins
// assumes one pulse request at a time on go_i
`timescale 1ns/100ps
module cti_src_model (
    // clock and camera state
    input  wire logic        clock_i,
    input  wire logic        ready_i,
    // request
    input  wire logic        go_i,
    input  wire logic [1:0]  line_i,
    input  wire logic [15:0] width_i,
    // pins, idle low
    output logic      [3:0]  pins_o
);
    initial pins_o = 4'h0;
    always begin
        @(posedge clock_i iff go_i);
        #1;
        while (!ready_i) begin
            @(posedge clock_i);
            #1;
        end
        pins_o[line_i] <= 1'b1;
        repeat (width_i) @(posedge clock_i);
        pins_o <= 4'h0;
    end
endmodule

// ### testbench/camera_trigger_io_unit_test.sv
// self-checking bench for the trigger i/o unit
// assumes a short readout and the source model
`timescale 1ns/100ps
module camera_trigger_io_unit_test;
    import cti_pkg::*;
    typedef struct {logic [7:0] a; logic [31:0] d, e;} cti_row_type;
    logic        clock_i = 1'b0;
    logic        reset_i = 1'b1;
    logic [7:0]  rg_a = 8'h00;
    logic [31:0] rg_d = 32'h0;
    logic        rg_w = 1'b0;
    logic        rg_r = 1'b0;
    logic        go = 1'b0;
    logic [1:0]  go_line = 2'h0;
    logic [15:0] go_w = 16'h0;
    logic [31:0] rdata;
    logic [3:0]  pins, lout, oe_n, lo;
    logic [3:0]  ut = 4'h5;
    logic        ready, expo, e;
    int          n_fail = 0, checks = 0, cyc = 0, fr, ex;
    cti_row_type rows [10] = '{'{OFF_DEBOUNCE, 32'h4E21, 32'h4E20},
        '{OFF_DEBOUNCE, 32'h4E20, 32'h4E20}, '{OFF_BURST, 32'h0, 32'h1},
        '{OFF_BURST, 32'h3FF, 32'h3FF}, '{OFF_USER, 32'hFF, 32'h7}, '{8'h3C, 32'hFF, 32'h0},
        '{OFF_CTRL, 32'hFF, 32'h3F}, '{OFF_STROBE, 32'h12345, 32'h2345},
        '{OFF_LINE_SEL, 32'h5, 32'h1}, '{OFF_STATUS, 32'h0, 32'h1}};
    cti_top #(.READOUT_US(2)) cti_top_inst (.clock_i(clock_i), .reset_i(reset_i),
        .reg_addr_i(rg_a), .reg_wdata_i(rg_d), .reg_write_i(rg_w), .reg_read_i(rg_r),
        .reg_rdata_o(rdata), .line_in_i(pins), .line_out_o(lout), .line_oe_n_o(oe_n),
        .trigger_ready_o(ready), .exposing_o(expo));
    cti_src_model cti_src_model_inst (.clock_i(clock_i), .ready_i(ready), .go_i(go),
        .line_i(go_line), .width_i(go_w), .pins_o(pins));
    always #50 clock_i = ~clock_i;
    task tick(input int k);
        repeat (k) @(posedge clock_i);
        #1;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        rg_a <= a;
        rg_d <= d;
        rg_w <= 1'b1;
        @(posedge clock_i);
        rg_w <= 1'b0;
        #1;
    endtask
    task rd(input logic [7:0] a);
        rg_a <= a;
        rg_r <= 1'b1;
        @(posedge clock_i);
        rg_r <= 1'b0;
        #1;
    endtask
    task fire(input logic [1:0] l, input logic [15:0] w);
        go_line <= l;
        go_w <= w;
        go <= 1'b1;
        @(posedge clock_i);
        go <= 1'b0;
        #1;
    endtask
    // counts frames and exposed cycles, keeps lines at the probe
    task run(input int probe);
        logic pe;
        pe = 1'b0;
        fr = 0;
        ex = 0;
        for (int i = 1; i <= 300; i++) begin
            tick(1);
            ex += (expo === 1'b1);
            fr += (expo === 1'b1 && !pe);
            pe = (expo === 1'b1);
            if (i == probe) lo = lout;
        end
    endtask
    task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task end_of_test;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    always @(posedge clock_i) begin
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            end_of_test;
        end
    end
    initial begin
        tick(4);
        reset_i <= 1'b0;
        wr(OFF_LINE_SEL, 32'h1);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a);
            chk("reg", rdata, rows[i].e);
        end
        wr(OFF_USER, 32'h5);
        for (int n = 0; n < 4; n++) begin
            for (int m = 0; m < 8; m++) begin
                wr(OFF_LINE_SEL, 32'(n));
                wr(OFF_LINE_CFG, 32'(1 + 2 * m));
                tick(3);
                e = (m / 2 == 0) || (m / 2 == 3 && ut[n]);
                chk("line", {oe_n[n], lout[n]}, {1'b0, e ^ 1'(m % 2)});
            end
        end
        reset_i <= 1'b1;
        tick(2);
        reset_i <= 1'b0;
        tick(1);
        chk("reset", {ready, expo, oe_n}, 6'h2F);
        wr(OFF_LINE_SEL, 32'h2);
        wr(OFF_LINE_CFG, 32'h5);
        wr(OFF_LINE_SEL, 32'h3);
        wr(OFF_LINE_CFG, 32'h9);
        wr(OFF_EXPOSE, 32'h3);
        wr(OFF_CTRL, 32'h1);
        wr(OFF_SOFT, 32'h1);
        run(5);
        chk("frames", fr, 1);
        chk("expose", ex inside {[21:31]}, 1);
        chk("lines", lo[3:2], 2'h3);
        chk("ready", ready, 1'b1);
        wr(OFF_BURST, 32'h2);
        wr(OFF_STROBE, 32'h1);
        wr(OFF_SOFT, 32'h1);
        wr(OFF_SOFT, 32'h1);
        run(20);
        chk("frames", fr, 2);
        chk("lines", lo[3:2], 2'h1);
        wr(OFF_BURST, 32'h1);
        wr(OFF_CTRL, 32'h9);
        fire(2'h0, 16'h39);
        run(0);
        chk("width", ex, 57);
        fire(2'h1, 16'h39);
        run(0);
        chk("frames", fr, 0);
        wr(OFF_CTRL, 32'h13);
        wr(OFF_LINE_SEL, 32'h1);
        wr(OFF_DEBOUNCE, 32'h5);
        fire(2'h1, 16'h31);
        run(0);
        chk("frames", fr, 0);
        fire(2'h1, 16'h50);
        run(0);
        chk("frames", fr, 1);
        end_of_test;
    end
endmodule
